/* File: cwr_config_reset.sv */
// Implementation choice: register access over AXI4-Lite.
`timescale 1ns/1ns
module cwr_config_reset #(
  parameter int PutCycles = cwr_pkg::CWR_PUT_CYC
) (
  input wire logic clk,
  input wire logic resetn,
  // Non-volatile word, stable while reset is held
  input wire logic [cwr_pkg::CWR_CFG_W-1:0] nvmConfigWord,
  input wire logic lowVoltageProgramming,
  // Reset source pulses from the analog and core side
  input wire logic porEvent,
  input wire logic borEvent,
  input wire logic lowPowerBrownEvent,
  input wire logic resetPinN,
  input wire logic watchdogEvent,
  input wire logic resetInstr,
  input wire logic progModeExit,
  input wire logic sleepMode,
  input wire logic portEPullupBit3,
  // Stack push/pop from the core
  input wire logic stackPush,
  input wire logic stackPop,
  input wire logic [cwr_pkg::CWR_STK_W-1:0] stackPushData,
  output logic [cwr_pkg::CWR_STK_W-1:0] stackTop,
  // Decoded outputs
  output logic clockOutputEnable,
  output logic brownoutActive,
  output logic watchdogActive,
  output logic codeProtect,
  output logic externalResetEnable,
  output logic resetPinPullup,
  output logic internalOscSelect,
  output logic [1:0] extClockRange,
  output logic coreResetN,
  output cwr_pkg::cwr_src_e lastResetSource,
  // AXI4-Lite slave
  input wire logic [13:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [13:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import cwr_pkg::*;

  // ****************************************************************
  // State record
  // ****************************************************************
  typedef struct packed {
    logic [CWR_CFG_W-1:0] cfg; // Latched configuration word
    logic lowVolt; // Latched programming mode strap
    logic [7:0] borCtl; // Brownout control register
    logic swWdt; // Software watchdog enable
    logic stack_overflow_flag; // Sticky overflow flag
    logic stack_underflow_flag; // Sticky underflow flag
    logic stkRstEn; // Stack fault reset enable
    logic [4:0] sp; // Stack pointer, 0..16
    logic [31:0] rstCnt; // Reset hold counter
    logic inReset; // Core held in reset
    cwr_src_e src; // Last reset cause
    logic [1:0] pinSync; // Reset pin synchroniser
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    logic [CWR_STK_W-1:0] top; // Registered top stack entry
  } cwr_state_s;

  cwr_state_s st_q, st_d;
  logic [CWR_STK_W-1:0] stackMem [CWR_STK_DEPTH]; // Return stack storage
  logic [CWR_CFG_W-1:0] cfgView; // Word as software reads it
  logic [1:0] borMode, wdtMode;
  logic pinResetReq, stkFault, ovfEvt, unfEvt, doPush, doPop;
  logic wrGo, rdGo;

  // ****************************************************************
  // Field decode
  // ****************************************************************
  // Unimplemented bits forced to one regardless of storage
  assign cfgView = st_q.cfg | CWR_CFG_ONES;
  assign borMode = cfgView[CWR_B_BORHI:CWR_B_BORLO];
  assign wdtMode = cfgView[CWR_B_WDTHI:CWR_B_WDTLO];

  always_comb begin
    // Clock out pin only when its bit is cleared
    clockOutputEnable = ~cfgView[CWR_B_CLKOUTN];
    // Brownout mode select
    case (borMode)
      CWR_MODE_ON: brownoutActive = 1'b1;
      CWR_MODE_RUN: brownoutActive = ~sleepMode;
      CWR_MODE_SW: brownoutActive = st_q.borCtl[CWR_B_SWBOR];
      default: brownoutActive = 1'b0;
    endcase
    codeProtect = ~cfgView[CWR_B_CPN];
    // Programming mode keeps the pin as reset, select bit ignored
    if (st_q.lowVolt) begin
      externalResetEnable = 1'b1;
      resetPinPullup = 1'b1;
    end else begin
      externalResetEnable = cfgView[CWR_B_RSTSEL];
      resetPinPullup = cfgView[CWR_B_RSTSEL] | portEPullupBit3;
    end
    // Watchdog mode select
    case (wdtMode)
      CWR_MODE_ON: watchdogActive = 1'b1;
      CWR_MODE_RUN: watchdogActive = ~sleepMode;
      CWR_MODE_SW: watchdogActive = st_q.swWdt;
      default: watchdogActive = 1'b0;
    endcase
    // Oscillator select: 00 internal, else external range
    internalOscSelect = (cfgView[CWR_B_OSCHI:CWR_B_OSCLO] == CWR_OSC_INT);
    extClockRange = cfgView[CWR_B_OSCHI:CWR_B_OSCLO];
  end

  // ****************************************************************
  // Return stack
  // ****************************************************************
  // Push past full or pop from empty is a fault, not a wrap
  assign ovfEvt = stackPush && !stackPop && (st_q.sp == 5'(CWR_STK_DEPTH));
  assign unfEvt = stackPop && !stackPush && (st_q.sp == 5'h00);
  assign doPush = stackPush && !stackPop && !ovfEvt && !st_q.inReset;
  assign doPop = stackPop && !stackPush && !unfEvt && !st_q.inReset;
  assign stkFault = st_q.stkRstEn && (ovfEvt || unfEvt) && !st_q.inReset;

  // Memory array, kept out of the state record for size
  always_ff @(posedge clk) begin
    if (doPush) begin
      stackMem[st_q.sp[3:0]] <= stackPushData;
    end
  end

  // Pin reset seen only after both synchroniser stages
  assign pinResetReq = externalResetEnable && !st_q.pinSync[1];
  assign wrGo = s_axi_awvalid && s_axi_wvalid && !st_q.bvalid;
  assign rdGo = s_axi_arvalid && !st_q.rvalid;
  assign s_axi_awready = wrGo;
  assign s_axi_wready = wrGo;
  assign s_axi_arready = rdGo;

  // ****************************************************************
  // Next state
  // ****************************************************************
  always_comb begin
    st_d = st_q;
    st_d.pinSync = {st_q.pinSync[0], resetPinN};
    // Reset sequencer: any source restarts the hold
    if (porEvent || borEvent || lowPowerBrownEvent || pinResetReq || watchdogEvent ||
        resetInstr || stkFault || progModeExit) begin
      st_d.inReset = 1'b1;
      if (porEvent) begin
        st_d.src = CWR_SRC_POR;
      end else if (borEvent) begin
        st_d.src = CWR_SRC_BOR;
      end else if (lowPowerBrownEvent) begin
        st_d.src = CWR_SRC_LOWBROWN;
      end else if (pinResetReq) begin
        st_d.src = CWR_SRC_PIN;
      end else if (watchdogEvent) begin
        st_d.src = CWR_SRC_WDT;
      end else if (resetInstr) begin
        st_d.src = CWR_SRC_INSTR;
      end else if (stkFault) begin
        st_d.src = ovfEvt ? CWR_SRC_STKOVER : CWR_SRC_STKUNDER;
      end else begin
        st_d.src = CWR_SRC_PROG;
      end
      // POR and BOR events get the longer stretch when the timer is on
      if ((porEvent || borEvent) && !cfgView[CWR_B_PUTN]) begin
        st_d.rstCnt = 32'(PutCycles);
      end else begin
        st_d.rstCnt = 32'(CWR_BASE_CYC);
      end
      st_d.sp = 5'h00;
    end else if (st_q.inReset) begin
      // Word sampled every hold cycle, frozen once released
      st_d.cfg = nvmConfigWord;
      st_d.lowVolt = lowVoltageProgramming;
      if (st_q.rstCnt <= 32'h1) begin
        st_d.inReset = 1'b0;
      end else begin
        st_d.rstCnt = st_q.rstCnt - 32'h1;
      end
    end else if (doPush) begin
      st_d.sp = st_q.sp + 5'h01;
    end else if (doPop) begin
      st_d.sp = st_q.sp - 5'h01;
    end
    // Top entry in a register so the core never waits on the array
    if (doPush) begin
      st_d.top = stackPushData;
    end else if (doPop && st_q.sp > 5'h01) begin
      // Entry below the popped one becomes the new top
      st_d.top = stackMem[4'(st_q.sp - 5'h02)];
    end
    // Bus write; sticky flags cleared by writing zero
    if (st_q.bvalid && s_axi_bready) begin
      st_d.bvalid = 1'b0;
    end
    if (wrGo) begin
      st_d.bvalid = 1'b1;
      st_d.bresp = CWR_RESP_OK;
      case (s_axi_awaddr)
        CWR_ADDR_BORCTL: if (s_axi_wstrb[0]) begin
          st_d.borCtl[CWR_B_SWBOR] = s_axi_wdata[CWR_B_SWBOR];
          st_d.borCtl[CWR_B_BORFAST] = s_axi_wdata[CWR_B_BORFAST];
        end
        CWR_ADDR_PWRCTL: if (s_axi_wstrb[0]) begin
          st_d.stack_overflow_flag = st_q.stack_overflow_flag & s_axi_wdata[CWR_B_STKOVER];
          st_d.stack_underflow_flag = st_q.stack_underflow_flag & s_axi_wdata[CWR_B_STKUNDER];
        end
        CWR_ADDR_STKCTL: if (s_axi_wstrb[0]) begin
          st_d.stkRstEn = s_axi_wdata[CWR_B_STKRSTEN];
          st_d.swWdt = s_axi_wdata[CWR_B_SWWDT];
        end
        CWR_ADDR_CFG, CWR_ADDR_STATUS: ;
        default: st_d.bresp = CWR_RESP_SLVERR;
      endcase
    end
    // Hardware set wins over a same-cycle clear
    if (ovfEvt) begin
      st_d.stack_overflow_flag = 1'b1;
    end
    if (unfEvt) begin
      st_d.stack_underflow_flag = 1'b1;
    end
    // Ready mirrors brownout enable state
    st_d.borCtl[CWR_B_BORREADY] = brownoutActive;
    // Bus read
    if (st_q.rvalid && s_axi_rready) begin
      st_d.rvalid = 1'b0;
    end
    if (rdGo) begin
      st_d.rvalid = 1'b1;
      st_d.rresp = CWR_RESP_OK;
      st_d.rdata = 32'h0;
      case (s_axi_araddr)
        CWR_ADDR_BORCTL: st_d.rdata[7:0] = st_q.borCtl;
        CWR_ADDR_CFG: st_d.rdata[CWR_CFG_W-1:0] = cfgView;
        CWR_ADDR_PWRCTL: begin
          st_d.rdata[CWR_B_STKOVER] = st_q.stack_overflow_flag;
          st_d.rdata[CWR_B_STKUNDER] = st_q.stack_underflow_flag;
        end
        CWR_ADDR_STATUS: st_d.rdata[7:0] = {st_q.src, st_q.inReset, codeProtect,
                                           brownoutActive, watchdogActive};
        CWR_ADDR_STKCTL: st_d.rdata[7:0] = {st_q.sp[3:0], 2'b00, st_q.stkRstEn, st_q.swWdt};
        default: st_d.rresp = CWR_RESP_SLVERR;
      endcase
    end
  end

  // ****************************************************************
  // State register
  // ****************************************************************
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      st_q <= '{cfg: '1, lowVolt: 1'b1, borCtl: CWR_BORCTL_RST, swWdt: 1'b0, stack_overflow_flag: 1'b0,
                stack_underflow_flag: 1'b0, stkRstEn: CWR_STKCTL_RST[CWR_B_STKRSTEN], sp: 5'h00,
                rstCnt: 32'(CWR_BASE_CYC), inReset: 1'b1, src: CWR_SRC_POR,
                pinSync: 2'b11, bvalid: 1'b0, bresp: 2'h0, rvalid: 1'b0,
                rdata: 32'h0, rresp: 2'h0, top: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign coreResetN = ~st_q.inReset;
  assign stackTop = st_q.top;
  assign lastResetSource = st_q.src;
  assign s_axi_bvalid = st_q.bvalid;
  assign s_axi_bresp = st_q.bresp;
  assign s_axi_rvalid = st_q.rvalid;
  assign s_axi_rdata = st_q.rdata;
  assign s_axi_rresp = st_q.rresp;

  // ****************************************************************
  // Checks
  // ****************************************************************
  // Watch the bus answer itself, not the forced view
  a_cfg_ones_read: assert property (@(posedge clk) disable iff (!resetn)
    (rdGo && s_axi_araddr == CWR_ADDR_CFG) |=>
      ((s_axi_rdata[CWR_CFG_W-1:0] & CWR_CFG_ONES) == CWR_CFG_ONES))
    else $error("unimplemented cfg bit low");
  a_clock_output_pin_pin: assert property (@(posedge clk) disable iff (!resetn)
    clockOutputEnable != cfgView[CWR_B_CLKOUTN]) else $error("clock out mismatch");
  a_bor_off_mode: assert property (@(posedge clk) disable iff (!resetn)
    (borMode == CWR_MODE_OFF) |-> !brownoutActive) else $error("brownout on when off");
  a_code_protect: assert property (@(posedge clk) disable iff (!resetn)
    codeProtect == !cfgView[CWR_B_CPN]) else $error("code protect mismatch");
  a_lowvolt_pin_reset: assert property (@(posedge clk) disable iff (!resetn)
    st_q.lowVolt |-> externalResetEnable) else $error("pin reset lost in low voltage mode");
  a_wdt_sw_mode: assert property (@(posedge clk) disable iff (!resetn)
    (wdtMode == CWR_MODE_SW) |-> (watchdogActive == st_q.swWdt)) else $error("wdt sw mode");
  a_ovf_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    ovfEvt |=> st_q.stack_overflow_flag) else $error("overflow flag not set");
  a_stk_reset: assert property (@(posedge clk) disable iff (!resetn)
    stkFault |=> (st_q.inReset && !coreResetN)) else $error("stack fault no reset");
  a_cfg_frozen: assert property (@(posedge clk) disable iff (!resetn)
    (!st_q.inReset && !$past(st_q.inReset)) |-> $stable(st_q.cfg)) else $error("cfg moved");
  a_sp_bound: assert property (@(posedge clk) disable iff (!resetn)
    st_q.sp <= 5'(CWR_STK_DEPTH)) else $error("stack pointer out of range");
  // Always-on brownout mode must never drop out
  a_bor_on_mode: assert property (@(posedge clk) disable iff (!resetn)
    (borMode == CWR_MODE_ON) |-> brownoutActive) else $error("brownout off when on");
  // Watchdog field at zero keeps the timer off
  a_wdt_off_mode: assert property (@(posedge clk) disable iff (!resetn)
    (wdtMode == CWR_MODE_OFF) |-> !watchdogActive) else $error("watchdog on when off");
  // Input-pin mode hands the pull-up to the port bit
  a_pin_input_mode: assert property (@(posedge clk) disable iff (!resetn)
    (!st_q.lowVolt && !cfgView[CWR_B_RSTSEL]) |->
      (!externalResetEnable && (resetPinPullup == portEPullupBit3)))
    else $error("pin input mode wrong");
  // POR and BOR events with the timer on load the long hold
  a_put_stretch: assert property (@(posedge clk) disable iff (!resetn)
    ((porEvent || borEvent) && !cfgView[CWR_B_PUTN]) |=> (st_q.rstCnt == 32'(PutCycles)))
    else $error("power-up stretch not loaded");
  // Instruction, watchdog and programming-exit sources restart the hold
  a_src_restart: assert property (@(posedge clk) disable iff (!resetn)
    (resetInstr || watchdogEvent || progModeExit) |=> !coreResetN) else $error("source ignored");
  // Underflow flag follows its event
  a_unf_flag_set: assert property (@(posedge clk) disable iff (!resetn)
    unfEvt |=> st_q.stack_underflow_flag) else $error("underflow flag not set");
  // A push lands in the top entry one cycle later
  a_push_top: assert property (@(posedge clk) disable iff (!resetn)
    doPush |=> (stackTop == $past(stackPushData))) else $error("push lost");
endmodule // cwr_config_reset

/* File: cwr_pkg.sv */
package cwr_pkg;
  // ****************************************************************
  // Register indices and byte addresses (four bytes per index)
  // ****************************************************************
  localparam logic [11:0] CWR_IDX_BORCTL = 12'h116; // Brownout control index
  localparam logic [11:0] CWR_IDX_CFG = 12'h200; // Config word view index
  localparam logic [11:0] CWR_IDX_PWRCTL = 12'h201; // Power control index
  localparam logic [11:0] CWR_IDX_STATUS = 12'h202; // Decoded status index
  localparam logic [11:0] CWR_IDX_STKCTL = 12'h203; // Stack control index
  localparam logic [13:0] CWR_ADDR_BORCTL = {CWR_IDX_BORCTL, 2'b00};
  localparam logic [13:0] CWR_ADDR_CFG = {CWR_IDX_CFG, 2'b00};
  localparam logic [13:0] CWR_ADDR_PWRCTL = {CWR_IDX_PWRCTL, 2'b00};
  localparam logic [13:0] CWR_ADDR_STATUS = {CWR_IDX_STATUS, 2'b00};
  localparam logic [13:0] CWR_ADDR_STKCTL = {CWR_IDX_STKCTL, 2'b00};
  // ****************************************************************
  // Configuration word fields
  // ****************************************************************
  localparam int CWR_CFG_W = 14;
  localparam logic [13:0] CWR_CFG_ONES = 14'h3104; // Bits 13,12,8,2
  localparam int CWR_B_CLKOUTN = 11;
  localparam int CWR_B_BORHI = 10;
  localparam int CWR_B_BORLO = 9;
  localparam int CWR_B_CPN = 7;
  localparam int CWR_B_RSTSEL = 6;
  localparam int CWR_B_PUTN = 5;
  localparam int CWR_B_WDTHI = 4;
  localparam int CWR_B_WDTLO = 3;
  localparam int CWR_B_OSCHI = 1;
  localparam int CWR_B_OSCLO = 0;
  // Two-bit mode encodings shared by brownout and watchdog
  localparam logic [1:0] CWR_MODE_OFF = 2'h0;
  localparam logic [1:0] CWR_MODE_SW = 2'h1;
  localparam logic [1:0] CWR_MODE_RUN = 2'h2;
  localparam logic [1:0] CWR_MODE_ON = 2'h3;
  localparam logic [1:0] CWR_OSC_INT = 2'h0;
  // ****************************************************************
  // Register bit positions and reset values
  // ****************************************************************
  localparam int CWR_B_SWBOR = 7; // Brownout control bit 7
  localparam int CWR_B_BORFAST = 6;
  localparam int CWR_B_BORREADY = 0;
  localparam int CWR_B_SWWDT = 0; // Stack control register bit 0
  localparam int CWR_B_STKOVER = 7; // Power control flags
  localparam int CWR_B_STKUNDER = 6;
  localparam int CWR_B_STKRSTEN = 1; // Stack control reset enable
  localparam logic [7:0] CWR_BORCTL_RST = 8'h80;
  localparam logic [7:0] CWR_STKCTL_RST = 8'h02;
  // ****************************************************************
  // Stack and timing
  // ****************************************************************
  localparam int CWR_STK_DEPTH = 16;
  localparam int CWR_STK_W = 15;
  localparam int CWR_CLK_MHZ = 125;
  localparam int CWR_PUT_US = 64; // Power-up stretch, microseconds
  localparam int CWR_PUT_CYC = CWR_PUT_US * CWR_CLK_MHZ;
  localparam int CWR_BASE_CYC = 16; // Minimal reset hold, cycles
  localparam logic [1:0] CWR_RESP_OK = 2'h0;
  localparam logic [1:0] CWR_RESP_SLVERR = 2'h2;
  // Reset cause encoding
  typedef enum logic [3:0] {
    CWR_SRC_NONE, CWR_SRC_POR, CWR_SRC_BOR, CWR_SRC_LOWBROWN, CWR_SRC_PIN,
    CWR_SRC_WDT, CWR_SRC_INSTR, CWR_SRC_STKOVER, CWR_SRC_STKUNDER, CWR_SRC_PROG
  } cwr_src_e;
endpackage : cwr_pkg

/* File: cwr_tb.sv */
`timescale 1ns/1ns
module testbench;
  import cwr_pkg::*;
  // ************************************************************
  // Signals and bench state
  // ************************************************************
  typedef struct packed {logic [31:0] d; logic [31:0] m; logic [1:0] r;} cwr_note_s;
  localparam int PUT = 20; // Short stretch keeps the run brief
  logic clk, resetn, lowVolt, sleepMode, pullE, porEv, borEv, lowBrownEv, pinN, wdtEv;
  logic instrEv, progEv;
  logic push, pop, clock_output_pin, borAct, wdtAct, codeProt, extRst, pinPu, internal_oscillator, coreN;
  logic [13:0] word;
  logic [14:0] pushData, top;
  logic [1:0] range;
  cwr_src_e src;
  logic [13:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
  int numErrors, checksDone, cyc, seed;
  cwr_note_s notes[$]; // Expected read answers, oldest first
  cwr_src_e srcs[7] = '{CWR_SRC_POR, CWR_SRC_BOR, CWR_SRC_LOWBROWN, CWR_SRC_WDT, CWR_SRC_INSTR,
                        CWR_SRC_PROG, CWR_SRC_PIN};
  cwr_config_reset #(.PutCycles(PUT)) u_dut (.clk(clk), .resetn(resetn), .nvmConfigWord(word),
    .lowVoltageProgramming(lowVolt), .porEvent(porEv), .borEvent(borEv),
    .lowPowerBrownEvent(lowBrownEv),
    .resetPinN(pinN), .watchdogEvent(wdtEv), .resetInstr(instrEv), .progModeExit(progEv),
    .sleepMode(sleepMode), .portEPullupBit3(pullE), .stackPush(push), .stackPop(pop),
    .stackPushData(pushData), .stackTop(top), .clockOutputEnable(clock_output_pin),
    .brownoutActive(borAct), .watchdogActive(wdtAct), .codeProtect(codeProt),
    .externalResetEnable(extRst), .resetPinPullup(pinPu), .internalOscSelect(internal_oscillator),
    .extClockRange(range), .coreResetN(coreN), .lastResetSource(src),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
  // ************************************************************
  // Clock, timeout and reporting
  // ************************************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic wrapUp();
    $display("checks %0d errors %0d", checksDone, numErrors);
    if (numErrors == 0 && checksDone > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask
  // Hang guard, far above the several hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 20000) begin
      numErrors++;
      wrapUp();
    end
  end
  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      numErrors++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  // Read monitor: pairs each accepted answer with the oldest note
  always @(posedge clk) begin
    cwr_note_s n;
    if (rvalid === 1'b1 && rready === 1'b1) begin
      n = notes.pop_front();
      check("rdata", rdata & n.m, n.d);
      check("rresp", 32'(rresp), 32'(n.r));
    end
  end
  // ************************************************************
  // Bus and event tasks
  // ************************************************************
  // Waits for the answer; only the hang guard ends a lost one
  task automatic wr(input logic [13:0] a, input logic [31:0] d, input logic [1:0] r);
    logic done;
    done = 1'b0;
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid && bready) begin
        check("bresp", 32'(bresp), 32'(r));
        bready <= 1'b0;
        done = 1'b1;
      end
    end
    // Gap edge so a following call never reassigns in one step
    @(posedge clk);
  endtask
  // Notes the expectation, then reads; the monitor compares
  task automatic rd(input logic [13:0] a, input logic [31:0] d, input logic [31:0] m,
                    input logic [1:0] r);
    logic done;
    done = 1'b0;
    notes.push_back('{d, m, r});
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    while (!done) begin
      @(posedge clk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid && rready) begin
        rready <= 1'b0;
        done = 1'b1;
      end
    end
    @(posedge clk);
  endtask
  // One-cycle pulse of source k; -1 leaves every source idle
  task automatic evt(input int k);
    porEv <= (k == 0);
    borEv <= (k == 1);
    lowBrownEv <= (k == 2);
    wdtEv <= (k == 3);
    instrEv <= (k == 4);
    progEv <= (k == 5);
    pinN <= (k != 6);
  endtask
  // Length of the core reset hold that follows an event
  task automatic measure(output int n);
    n = 0;
    for (int i = 0; i < 50 && coreN !== 1'b0; i++) @(posedge clk);
    for (int i = 0; i < 200 && coreN !== 1'b1; i++) begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic doReset(input logic [13:0] w, input logic l);
    int n;
    resetn <= 1'b0;
    word <= w;
    lowVolt <= l;
    sleepMode <= 1'($random(seed));
    pullE <= 1'($random(seed));
    repeat (10) @(posedge clk);
    resetn <= 1'b1;
    measure(n);
  endtask
  // Expected decode, with software enables at their reset values
  task automatic checkDecode(input logic [13:0] w, input logic l);
    logic [1:0] b, t;
    b = w[10:9];
    t = w[4:3];
    check("clock_output_pin", 32'(clock_output_pin), 32'(!w[11]));
    check("bor", 32'(borAct), 32'(b == 3 || (b == 2 && !sleepMode) || b == 1));
    check("codeprot", 32'(codeProt), 32'(!w[7]));
    check("extrst", 32'(extRst), 32'(l | w[6]));
    check("pullup", 32'(pinPu), 32'((l | w[6]) ? 1'b1 : pullE));
    check("wdt", 32'(wdtAct), 32'(t == 3 || (t == 2 && !sleepMode)));
    check("internal_oscillator", 32'(internal_oscillator), 32'(w[1:0] == 0));
    check("range", 32'(range), 32'(w[1:0]));
  endtask
  // ************************************************************
  // Main sequence
  // ************************************************************
  initial begin
    int cnt[7];
    logic [13:0] w;
    logic l;
    logic [14:0] last;
    seed = 32'h2988C165;
    {resetn, lowVolt, sleepMode, pullE, push, pop, awvalid, wvalid, bready, arvalid, rready} = '0;
    evt(-1);
    {word, pushData, awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    // Let one edge pass before the first driven reset
    @(posedge clk);
    // Random words; the latched view must ignore later changes
    for (int i = 0; i < 6; i++) begin
      w = 14'($random(seed));
      l = 1'($random(seed));
      doReset(w, l);
      checkDecode(w, l);
      word <= ~w;
      lowVolt <= ~l;
      repeat (3) @(posedge clk);
      checkDecode(w, l);
      rd(CWR_ADDR_CFG, {18'h0, w | CWR_CFG_ONES}, 32'hFFFFFFFF, CWR_RESP_OK);
    end
    // Software-controlled modes, unmapped places
    doReset(14'h3BCF, 1'b0);
    rd(CWR_ADDR_BORCTL, 32'h81, 32'hC1, CWR_RESP_OK);
    wr(CWR_ADDR_BORCTL, 32'h40, CWR_RESP_OK);
    check("borsw", 32'(borAct), 32'h0);
    rd(CWR_ADDR_BORCTL, 32'h40, 32'hC1, CWR_RESP_OK);
    wr(CWR_ADDR_STKCTL, 32'h03, CWR_RESP_OK);
    check("wdtsw", 32'(wdtAct), 32'h1);
    rd(14'h3FF0, 32'h0, 32'h0, CWR_RESP_SLVERR);
    wr(14'h3FF0, 32'h0, CWR_RESP_SLVERR);
    // Fill the stack, then overflow and underflow it
    push <= 1'b1;
    for (int i = 0; i < CWR_STK_DEPTH; i++) begin
      last = 15'($random(seed));
      pushData <= last;
      @(posedge clk);
    end
    push <= 1'b0;
    @(posedge clk);
    check("top", 32'(top), 32'(last));
    push <= 1'b1;
    @(posedge clk);
    push <= 1'b0;
    measure(cnt[0]);
    check("ovfsrc", 32'(src), 32'(CWR_SRC_STKOVER));
    rd(CWR_ADDR_PWRCTL, 32'h80, 32'h80, CWR_RESP_OK);
    pop <= 1'b1;
    @(posedge clk);
    pop <= 1'b0;
    measure(cnt[0]);
    check("unfsrc", 32'(src), 32'(CWR_SRC_STKUNDER));
    rd(CWR_ADDR_PWRCTL, 32'hC0, 32'hC0, CWR_RESP_OK);
    // Status: cause, out of hold, no protection, brownout off, watchdog on
    rd(CWR_ADDR_STATUS, {24'h0, 4'(CWR_SRC_STKUNDER), 4'h1}, 32'hFF, CWR_RESP_OK);
    // Writing zero clears both sticky flags
    wr(CWR_ADDR_PWRCTL, 32'h0, CWR_RESP_OK);
    rd(CWR_ADDR_PWRCTL, 32'h0, 32'hC0, CWR_RESP_OK);
    // Every source but the stack faults, with and without the power-up stretch
    for (int j = 0; j < 2; j++) begin
      w = j ? 14'h3FFF : 14'h3FDF;
      doReset(w, 1'b0);
      for (int k = 0; k < 7; k++) begin
        evt(k);
        @(posedge clk);
        evt(-1);
        measure(cnt[k]);
        check("src", 32'(src), 32'(srcs[k]));
      end
      for (int k = 0; k < 3; k++) begin
        check("hold", 32'(cnt[k] - cnt[3]), 32'((!w[5] && k < 2) ? PUT - CWR_BASE_CYC : 0));
      end
    end
    repeat (5) @(posedge clk);
    wrapUp();
  end
endmodule // testbench
